// ### rtl/pmp_poller.sv
// PHY management poller: autonomous presence and link polling of 32 PHY
// addresses plus one software access channel with completion flags.
// Assumes all control inputs are synchronous to CLK and that write-one
// clear inputs are single-cycle pulses.
`timescale 1ns/1ps
module pmp_poller
   import pmp_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        ENABLE,
   input  wire logic [15:0] CLK_DIV,
   input  wire logic        NO_PREAMBLE,
   input  wire logic        ACC_GO,
   input  wire pmp_req_s    ACC_REQ,
   output logic             ACC_BUSY,
   output pmp_rsp_s         ACC_RSP,
   input  wire logic        ACC_DONE_MASK_SET,
   input  wire logic        ACC_DONE_MASK_CLR,
   input  wire logic        ACC_DONE_CLR,
   output logic             ACC_DONE_RAW,
   output logic             ACC_DONE_MASKED,
   output logic             ACC_DONE_IRQ,
   input  wire logic [4:0]  MONITORED_PHY_SELECT,
   input  wire logic        LINK_CHANGE_IRQ_ENABLE,
   input  wire logic        LINK_CHANGE_CLR,
   output logic             LINK_CHANGE_RAW,
   output logic             LINK_CHANGE_MASKED,
   output logic             LINK_CHANGE_IRQ,
   output logic [31:0]      PHY_ALIVE,
   output logic [31:0]      PHY_LINK,
   output logic             MDC,
   input  wire logic        MDIO_I,
   output logic             MDIO_O,
   output logic             MDIO_OE_N
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   pmp_poll_e   st_q, st_d;
   logic [4:0]  addr_q, addr_d;
   logic        user_q, user_d;
   logic        go_q, go_d;
   pmp_req_s    req_q, req_d;
   pmp_rsp_s    rsp_q, rsp_d;
   logic [31:0] alive_q, alive_d, link_q, link_d;
   logic        mask_q, mask_d, draw_q, draw_d, dmsk_q, dmsk_d;
   logic        lraw_q, lraw_d, lmsk_q, lmsk_d;
   logic        f_start, f_busy, f_done, acc_ev, link_ev, new_link;
   pmp_req_s    f_req;
   pmp_rsp_s    f_rsp;

   // ---------------------------------------------------------------
   // Frame engine
   // ---------------------------------------------------------------
   // Polls and user accesses share one frame engine; only one frame runs at a time.
   pmp_frame u_frame (
      .clk         (CLK),
      .rst         (SYS_RST),
      .start       (f_start),
      .no_preamble (NO_PREAMBLE),
      .div         (CLK_DIV),
      .req         (f_req),
      .mdio_i      (MDIO_I),
      .busy        (f_busy),
      .done        (f_done),
      .rsp         (f_rsp),
      .mdc         (MDC),
      .mdio_o      (MDIO_O),
      .mdio_oe_n   (MDIO_OE_N)
   );

   // ---------------------------------------------------------------
   // Poll scheduler and user access
   // ---------------------------------------------------------------
   // Polls read the basic status register; a PHY that drives the ack bit
   // low is present, and the link status bit gives its link state.
   always_comb begin
      st_d     = st_q;
      addr_d   = addr_q;
      user_d   = user_q;
      go_d     = go_q;
      req_d    = req_q;
      rsp_d    = rsp_q;
      alive_d  = alive_q;
      link_d   = link_q;
      f_start  = 1'b0;
      f_req    = '{write: 1'b0, phy: addr_q, reg_addr: POLL_REG_ADDR, wdata: 16'h0000};
      acc_ev   = 1'b0;
      link_ev  = 1'b0;
      // An absent PHY reads as link down.
      new_link = f_rsp.ack & f_rsp.rdata[LINK_BIT_POS];
      // A go that arrives while an access is pending is ignored, so the
      // request in flight can never be overwritten half way.
      if (ACC_GO && !go_q) begin
         go_d    = 1'b1;
         req_d   = ACC_REQ;
         rsp_d   = '0;
      end
      case (st_q)
         PL_IDLE: begin
            // User accesses go first, so software waits at most one poll frame.
            if (go_q && !f_busy) begin
               f_req   = req_q;
               f_start = 1'b1;
               user_d  = 1'b1;
               st_d    = PL_WAIT;
            end else if (ENABLE && !f_busy) begin
               f_start = 1'b1;
               user_d  = 1'b0;
               st_d    = PL_WAIT;
            end
         end
         PL_WAIT: begin
            if (f_done) begin
               st_d = PL_IDLE;
               if (user_q) begin
                  go_d   = 1'b0;
                  acc_ev = 1'b1;
                  rsp_d  = req_q.write ? '0 : f_rsp;
               end else begin
                  alive_d[addr_q] = f_rsp.ack;
                  link_d[addr_q]  = new_link;
                  link_ev = (addr_q == MONITORED_PHY_SELECT) && (new_link != link_q[addr_q]);
                  // The address wraps from 31 to 0 by the counter's own width.
                  addr_d  = addr_q + 5'h01;
               end
            end
         end
         default: st_d = PL_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // Event flags
   // ---------------------------------------------------------------
   // A new event wins over a clear arriving in the same cycle.
   always_comb begin
      // The mask clear wins over a mask set in the same cycle.
      mask_d = (mask_q | ACC_DONE_MASK_SET) & ~ACC_DONE_MASK_CLR;
      draw_d = (draw_q & ~ACC_DONE_CLR) | acc_ev;
      dmsk_d = draw_d & mask_d;
      lraw_d = (lraw_q & ~LINK_CHANGE_CLR) | link_ev;
      lmsk_d = lraw_d & LINK_CHANGE_IRQ_ENABLE;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Reset empties both bitmaps, so presence builds up afresh after it.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_q    <= PL_IDLE;
         addr_q  <= 5'h00;
         user_q  <= 1'b0;
         go_q    <= 1'b0;
         req_q   <= '0;
         rsp_q   <= '0;
         alive_q <= BITMAP_RST;
         link_q  <= BITMAP_RST;
         mask_q  <= 1'b0;
         draw_q  <= 1'b0;
         dmsk_q  <= 1'b0;
         lraw_q  <= 1'b0;
         lmsk_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         addr_q  <= addr_d;
         user_q  <= user_d;
         go_q    <= go_d;
         req_q   <= req_d;
         rsp_q   <= rsp_d;
         alive_q <= alive_d;
         link_q  <= link_d;
         mask_q  <= mask_d;
         draw_q  <= draw_d;
         dmsk_q  <= dmsk_d;
         lraw_q  <= lraw_d;
         lmsk_q  <= lmsk_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Interrupts are levels; the wrapper is expected to make edges of them.
   // Each interrupt mirrors its masked flag, so both clear together.
   assign ACC_BUSY           = go_q;
   assign ACC_RSP            = rsp_q;
   assign ACC_DONE_RAW       = draw_q;
   assign ACC_DONE_MASKED    = dmsk_q;
   assign ACC_DONE_IRQ       = dmsk_q;
   assign LINK_CHANGE_RAW    = lraw_q;
   assign LINK_CHANGE_MASKED = lmsk_q;
   assign LINK_CHANGE_IRQ    = lmsk_q;
   assign PHY_ALIVE          = alive_q;
   assign PHY_LINK           = link_q;

endmodule

// ### rtl/pmp_pkg.sv
// Shared constants and types of the PHY management poller.
// Assumes a single 50 MHz peripheral clock domain.
package pmp_pkg;

   // ---------------------------------------------------------------
   // Bus frame layout
   // ---------------------------------------------------------------
   localparam int          PHY_COUNT     = 32;
   localparam int          PREAMBLE_BITS = 32;
   localparam int          TA_BIT        = 46;
   localparam int          ACK_BIT       = 47;
   localparam int          LAST_BIT      = 63;
   localparam logic [1:0]  FRAME_START   = 2'h1;
   localparam logic [1:0]  OP_READ       = 2'h2;
   localparam logic [1:0]  OP_WRITE      = 2'h1;
   localparam logic [1:0]  TA_WRITE      = 2'h2;

   // ---------------------------------------------------------------
   // Polling and reset values
   // ---------------------------------------------------------------
   localparam logic [4:0]  POLL_REG_ADDR = 5'h01;
   localparam int          LINK_BIT_POS  = 2;
   localparam logic [31:0] BITMAP_RST    = 32'h0000_0000;
   localparam logic [15:0] HALF_MIN      = 16'h0001;

   typedef struct packed {
      logic        write;
      logic [4:0]  phy;
      logic [4:0]  reg_addr;
      logic [15:0] wdata;
   } pmp_req_s;

   typedef struct packed {
      logic        ack;
      logic [15:0] rdata;
   } pmp_rsp_s;

   typedef enum logic [1:0] {
      FR_IDLE = 2'b00,
      FR_LOW  = 2'b01,
      FR_HIGH = 2'b10
   } pmp_frame_e;

   typedef enum logic [0:0] {
      PL_IDLE = 1'b0,
      PL_WAIT = 1'b1
   } pmp_poll_e;

endpackage

// ### rtl/pmp_frame.sv
// Serial frame engine: shifts one management frame on the two-wire bus.
// Assumes the caller holds start for one cycle only while busy is low.
`timescale 1ns/1ps
module pmp_frame
   import pmp_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst,
   input  wire logic     start,
   input  wire logic     no_preamble,
   input  wire logic [15:0] div,
   input  wire pmp_req_s req,
   input  wire logic     mdio_i,
   output logic          busy,
   output logic          done,
   output pmp_rsp_s      rsp,
   output logic          mdc,
   output logic          mdio_o,
   output logic          mdio_oe_n
);

   pmp_frame_e  state_q, state_d;
   logic [15:0] cnt_q, cnt_d, half;
   logic [5:0]  bit_q, bit_d;
   logic [31:0] word_q, word_d;
   logic        rd_q, rd_d, done_q, done_d, mdc_q, mdc_d, mdo_q, mdo_d, oen_q, oen_d;
   pmp_rsp_s    rsp_q, rsp_d;

   // Bits below the preamble length are all ones; the rest come from the word.
   function automatic logic bit_val(input logic [31:0] w, input logic [5:0] k);
      bit_val = k[5] ? w[~k[4:0]] : 1'b1;
   endfunction

   // On a read the PHY owns the line from the turnaround onward.
   function automatic logic rel_n(input logic rd, input logic [5:0] k);
      rel_n = rd && (k >= 6'(TA_BIT));
   endfunction

   // --------------------------------------------------------------
   // Clock divider and shifter
   // --------------------------------------------------------------
   // The divider gives a full bus clock period of div input cycles; odd values round down, and values below 2 give 2.
   assign half = (div[15:1] == 15'h0000) ? HALF_MIN : {1'b0, div[15:1]};

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      bit_d   = bit_q;
      word_d  = word_q;
      rd_d    = rd_q;
      rsp_d   = rsp_q;
      mdc_d   = mdc_q;
      mdo_d   = mdo_q;
      oen_d   = oen_q;
      done_d  = 1'b0;
      case (state_q)
         FR_IDLE: begin
            if (start) begin
               word_d  = {FRAME_START, req.write ? OP_WRITE : OP_READ, req.phy,
                          req.reg_addr, TA_WRITE, req.wdata};
               rd_d    = ~req.write;
               bit_d   = no_preamble ? 6'(PREAMBLE_BITS) : 6'h00;
               mdo_d   = bit_val(word_d, bit_d);
               oen_d   = rel_n(rd_d, bit_d);
               mdc_d   = 1'b0;
               cnt_d   = 16'h0000;
               rsp_d   = '0;
               state_d = FR_LOW;
            end
         end
         FR_LOW: begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q == half - 16'h0001) begin
               cnt_d   = 16'h0000;
               mdc_d   = 1'b1;
               state_d = FR_HIGH;
               // Data is sampled as the bus clock rises.
               if (rd_q && bit_q == 6'(ACK_BIT)) begin
                  rsp_d.ack = ~mdio_i;
               end else if (rd_q && bit_q > 6'(ACK_BIT)) begin
                  rsp_d.rdata = {rsp_q.rdata[14:0], mdio_i};
               end
            end
         end
         FR_HIGH: begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q == half - 16'h0001) begin
               cnt_d = 16'h0000;
               mdc_d = 1'b0;
               if (bit_q == 6'(LAST_BIT)) begin
                  mdo_d   = 1'b1;
                  oen_d   = 1'b1;
                  done_d  = 1'b1;
                  state_d = FR_IDLE;
               end else begin
                  bit_d   = bit_q + 6'h01;
                  mdo_d   = bit_val(word_q, bit_d);
                  oen_d   = rel_n(rd_q, bit_d);
                  state_d = FR_LOW;
               end
            end
         end
         default: state_d = FR_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= FR_IDLE;
         cnt_q   <= 16'h0000;
         bit_q   <= 6'h00;
         word_q  <= 32'h0000_0000;
         rd_q    <= 1'b0;
         rsp_q   <= '0;
         mdc_q   <= 1'b0;
         mdo_q   <= 1'b1;
         oen_q   <= 1'b1;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         bit_q   <= bit_d;
         word_q  <= word_d;
         rd_q    <= rd_d;
         rsp_q   <= rsp_d;
         mdc_q   <= mdc_d;
         mdo_q   <= mdo_d;
         oen_q   <= oen_d;
         done_q  <= done_d;
      end
   end

   assign busy      = (state_q != FR_IDLE);
   assign done      = done_q;
   assign rsp       = rsp_q;
   assign mdc       = mdc_q;
   assign mdio_o    = mdo_q;
   assign mdio_oe_n = oen_q;

endmodule

// ### dv/pmp_phy_model.sv
// PHY population model: decodes management frames and answers reads.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
module pmp_phy_model
   import pmp_pkg::*;
(
   input  wire logic        rst,
   input  wire logic        mdc,
   input  wire logic        line,
   input  wire logic [31:0] alive,
   input  wire logic [31:0] link,
   output logic             oe,
   output logic             d,
   output logic [11:0]      hdr,
   output logic [15:0]      wd
);
   // ---------------------------------------------------------------
   // Frame decode and read answer
   // ---------------------------------------------------------------
   int          k = 0;
   logic        prev = 1'b1;
   logic [15:0] sh = 16'h0000;
   logic [15:0] rd;

   assign rd = {hdr[4:0], hdr[9:5], 3'h5, link[hdr[9:5]], 2'h2};

   always @(posedge mdc or posedge rst) begin
      if (rst) begin
         k = 0;
         prev = 1'b1;
      end else begin
         sh = {sh[14:0], line};
         if (k == 0 && !prev && line) k = 2;
         else if (k > 0) k = k + 1;
         prev = line;
         if (k == 14) hdr = sh[11:0];
         if (k == 32) begin
            wd = sh;
            k = 0;
            prev = 1'b1;
         end
      end
   end

   // Only listed addresses answer; an absent PHY leaves the line to the pull-up.
   always @(negedge mdc or posedge rst) begin
      if (rst || k < 15 || hdr[11:10] != OP_READ || !alive[hdr[9:5]]) begin
         oe <= 1'b0;
      end else begin
         oe <= 1'b1;
         d  <= (k == 15) ? 1'b0 : rd[31-k];
      end
   end
endmodule

// ### dv/pmp_poller_properties.sv
// Checker of the poller's flag and access timing at its ports.
// Assumes one clock domain; bound to the poller below.
`timescale 1ns/1ps
module pmp_poller_properties
   import pmp_pkg::*;
(
   input wire logic        CLK,
   input wire logic        SYS_RST,
   input wire logic        ACC_GO,
   input wire logic        ACC_BUSY,
   input wire logic        ACC_DONE_CLR,
   input wire logic        ACC_DONE_RAW,
   input wire logic        ACC_DONE_MASKED,
   input wire logic        ACC_DONE_IRQ,
   input wire logic        LINK_CHANGE_CLR,
   input wire logic        LINK_CHANGE_RAW,
   input wire logic        LINK_CHANGE_MASKED,
   input wire logic        LINK_CHANGE_IRQ,
   input wire logic [31:0] PHY_LINK
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   a_go_sets_busy: assert property (ACC_GO && !ACC_BUSY |=> ACC_BUSY)
      else $error("busy did not follow an accepted go");
   a_busy_ends_bounded: assert property ($rose(ACC_BUSY) |-> ##[1:1000] !ACC_BUSY)
      else $error("access did not finish in time");
   a_fall_sets_done: assert property ($fell(ACC_BUSY) |-> ACC_DONE_RAW)
      else $error("done flag missing at end of access");
   a_done_irq_level: assert property (ACC_DONE_IRQ == ACC_DONE_MASKED)
      else $error("done interrupt differs from masked flag");
   a_done_mask_raw: assert property (ACC_DONE_MASKED |-> ACC_DONE_RAW)
      else $error("masked done flag without raw flag");
   a_done_holds: assert property (ACC_DONE_RAW && !ACC_DONE_CLR |=> ACC_DONE_RAW)
      else $error("done flag dropped without a clear");
   a_done_clears: assert property (ACC_DONE_CLR && !ACC_BUSY |=> !ACC_DONE_RAW)
      else $error("done flag survived its clear");
   a_link_holds: assert property (LINK_CHANGE_RAW && !LINK_CHANGE_CLR |=> LINK_CHANGE_RAW)
      else $error("link change flag dropped without a clear");
   a_link_cause: assert property ($rose(LINK_CHANGE_RAW) |-> PHY_LINK != $past(PHY_LINK))
      else $error("link change flag without a link bitmap change");
   a_link_irq_raw: assert property (LINK_CHANGE_IRQ |-> LINK_CHANGE_RAW && LINK_CHANGE_MASKED)
      else $error("link interrupt without its flags");
endmodule

bind pmp_poller pmp_poller_properties u_chk (
   .CLK(CLK), .SYS_RST(SYS_RST), .ACC_GO(ACC_GO), .ACC_BUSY(ACC_BUSY),
   .ACC_DONE_CLR(ACC_DONE_CLR), .ACC_DONE_RAW(ACC_DONE_RAW),
   .ACC_DONE_MASKED(ACC_DONE_MASKED), .ACC_DONE_IRQ(ACC_DONE_IRQ),
   .LINK_CHANGE_CLR(LINK_CHANGE_CLR), .LINK_CHANGE_RAW(LINK_CHANGE_RAW),
   .LINK_CHANGE_MASKED(LINK_CHANGE_MASKED), .LINK_CHANGE_IRQ(LINK_CHANGE_IRQ),
   .PHY_LINK(PHY_LINK)
);

// ### dv/pmp_poller_tb.sv
// Bench of the poller: random PHY population, polling, link watch, accesses.
// Assumes the PHY model and the line pull-up are resolved here.
`timescale 1ns/1ps
module pmp_poller_tb import pmp_pkg::*;;
   logic        clk = 0, rst = 1, en = 0, nopre = 0, go = 0, mset = 0, mclr = 0;
   logic        dclr = 0, len = 0, lclr = 0;
   logic [15:0] div = 16'h0002, wdv;
   logic [4:0]  sel = 5'h00, p, q, r;
   pmp_req_s    req = '0;
   pmp_rsp_s    rsp;
   logic        busy, draw, dmask, dirq, lraw, lmask, lirq, mdc, mo, oen, line, oe, d;
   logic [31:0] alive, plink, am = 0, lm = 0;
   logic [11:0] hdr;
   logic [15:0] wd;
   int          n_errors = 0, cmp_count = 0, cyc_now = 0, last = 0, per = 0, c0, c1;
   int          seed = 32'h556b_ce8c;

   pmp_poller DUT (.CLK(clk), .SYS_RST(rst), .ENABLE(en), .CLK_DIV(div), .NO_PREAMBLE(nopre),
      .ACC_GO(go), .ACC_REQ(req), .ACC_BUSY(busy), .ACC_RSP(rsp), .ACC_DONE_MASK_SET(mset),
      .ACC_DONE_MASK_CLR(mclr), .ACC_DONE_CLR(dclr), .ACC_DONE_RAW(draw),
      .ACC_DONE_MASKED(dmask), .ACC_DONE_IRQ(dirq), .MONITORED_PHY_SELECT(sel),
      .LINK_CHANGE_IRQ_ENABLE(len), .LINK_CHANGE_CLR(lclr), .LINK_CHANGE_RAW(lraw),
      .LINK_CHANGE_MASKED(lmask), .LINK_CHANGE_IRQ(lirq), .PHY_ALIVE(alive),
      .PHY_LINK(plink), .MDC(mdc), .MDIO_I(line), .MDIO_O(mo), .MDIO_OE_N(oen));
   pmp_phy_model u_phy (.rst(rst), .mdc(mdc), .line(line), .alive(am), .link(lm),
      .oe(oe), .d(d), .hdr(hdr), .wd(wd));

   // The line has a pull-up, so a released bus reads high.
   assign line = !oen ? mo : (oe ? d : 1'b1);
   always #10 clk = ~clk;

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      @(negedge clk);
   endtask
   task automatic access(input logic w, input logic [4:0] a, input logic [4:0] g,
                         input logic [15:0] v, output int n);
      go = 1'b1;
      req = '{w, a, g, v};
      @(negedge clk);
      go = 1'b0;
      n = 1;
      while (busy !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic sweep;
      repeat (5000) @(negedge clk);
   endtask
   function automatic logic [15:0] rdx(input logic [4:0] a, input logic [4:0] g);
      return {g, a, 3'h5, lm[a], 2'h2};
   endfunction

   always @(posedge clk) begin
      cyc_now <= cyc_now + 1;
      if (cyc_now == 90000) begin
         n_errors++;
         final_report();
      end
   end
   always @(posedge mdc) begin
      per <= cyc_now - last;
      last <= cyc_now;
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      am = $random(seed) | 32'h8000_0001;
      lm = $random(seed);
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("idle", 32'({busy, mdc, mo, oen, draw, lraw}), 32'h0000_000c);
      chk("empty", alive, 32'h0000_0000);
      en = 1'b1;
      sweep();
      sweep();
      chk("alive", alive, am);
      chk("link", plink & am, lm & am);
      $display("poll test done");
      p = 5'($random(seed));
      q = p ^ 5'h01;
      r = p ^ 5'h02;
      am = am | (32'h1 << p) | (32'h1 << q);
      sel = p;
      len = 1'b1;
      sweep();
      pulse(lclr);
      chk("stale", lraw, 1'b0);
      lm[q] = ~lm[q];
      am[r] = 1'b0;
      sweep();
      chk("other", lraw, 1'b0);
      chk("gone", alive, am);
      chk("qlink", plink[q], lm[q]);
      lm[p] = ~lm[p];
      sweep();
      chk("change", {lraw, lmask, lirq}, 3'h7);
      sweep();
      chk("held", lraw, 1'b1);
      pulse(lclr);
      chk("cleared", {lraw, lirq}, 2'h0);
      $display("link test done");
      pulse(mset);
      for (int i = 0; i < 6; i++) begin
         p = (i == 0) ? 5'h1f : 5'($random(seed));
         r = 5'($random(seed));
         access(1'b0, p, r, 16'h0000, c0);
         chk("ack", rsp.ack, am[p]);
         if (am[p]) chk("rdata", rsp.rdata, rdx(p, r));
         chk("done", {draw, dmask, dirq}, 3'h7);
      end
      pulse(dclr);
      chk("dclr", {draw, dmask, dirq}, 3'h0);
      pulse(mclr);
      access(1'b0, 5'h00, 5'h03, 16'h0000, c0);
      chk("masked", {draw, dmask, dirq}, 3'h4);
      pulse(dclr);
      $display("access test done");
      en = 1'b0;
      repeat (300) @(negedge clk);
      wdv = 16'($random(seed));
      access(1'b1, p, r, wdv, c0);
      chk("hdr", hdr, {OP_WRITE, p, r});
      chk("wdata", wd, wdv);
      nopre = 1'b1;
      access(1'b1, p, r, wdv, c1);
      chk("short", 32'(c0 - c1), 32'd64);
      div = 16'h0006;
      // PHY q was made present above and is never removed.
      access(1'b0, q, 5'h02, 16'h0000, c0);
      chk("period", 32'(per), 32'd6);
      chk("slowrd", {15'h0000, rsp.ack, rsp.rdata}, {15'h0000, 1'b1, rdx(q, 5'h02)});
      $display("frame test done");
      final_report();
   end
endmodule
